// [common/poll_pkg.sv]
package poll_pkg;
	// ============================================================
	// data bus and status bit positions
	localparam int DATA_W = 16;
	localparam int ADDR_W = 23;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	localparam int SECT_TOGGLE_BIT = 2;
	// ============================================================
	// bus timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int READ_ACCESS_NS = 70;
	localparam int READ_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int STROBE_HIGH_NS = 20;
	localparam int STROBE_HIGH_CYCLES = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [15:0] RESET_CMD = 16'h00F0;
	// ============================================================
	// checking method and result
	typedef enum logic {METHOD_TOGGLE, METHOD_POLL} method_t;
	typedef enum logic [1:0] {
		RES_NONE, RES_DONE, RES_FAIL
	} result_t;
	typedef enum {
		ST_IDLE, ST_READ, ST_GAP, ST_EVAL, ST_RESET_WR, ST_FINISH
	} state_t;
endpackage

// [hdl/flash_op_status_polling.sv]
`timescale 1ns/1ps
// How it works
// R01 - polling status valid after last write strobe of the command
// R02 - program status bit reads inverse of programmed bit 7
// R03 - byte mode polling uses inverse of last loaded byte's bit 7
// R04 - programmed bit returns at end; host polls the programmed address
// R05 - protected program: polling active briefly, then array reads
// R06 - erase polls 0; reads 1 when done or erase suspended
// R07 - host polls an address inside a sector chosen for erase
// R08 - all-protected erase: polling briefly active, then array reads
// R09 - bit 7 may settle first; host trusts word only on later read
// R10 - timeout flag set: host rereads polling bit before deciding
// R11 - global toggle bit inverts every read while operation runs
// R12 - toggle bit valid before operation and during erase time-out
// R13 - all-protected erase: toggle briefly, then array reads
// R14 - protected program: toggle briefly, then array reads
// R15 - erase suspend stops the global toggle bit
// R16 - erase-suspend-program toggles until program completes
// R17 - sector toggle bit toggles within chosen erase sectors
// R18 - host reads status twice, compares toggle; equal means done
// R19 - toggling with timeout: recheck; still toggling means fail, reset
// R20 - polling read data used only for status decisions
// R21 - abandoned check restarts from the first step
// R22 - timeout flag high means operation did not complete
// R23 - idle device returns array contents, not status
module flash_op_status_polling
	import poll_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// user side
	input wire logic start,
	input wire logic abort,
	input wire method_t method,
	input wire logic [ADDR_W-1:0] poll_addr,
	input wire logic [7:0] expect_data,
	input wire logic is_erase,
	output logic busy,
	output logic done,
	output result_t result,
	output logic [DATA_W-1:0] last_status,
	// flash pins
	output logic [ADDR_W-1:0] flash_addr,
	output logic chip_sel_n,
	output logic out_strobe_n,
	output logic write_strobe_n,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe
);
	// ============================================================
	// pin synchroniser
	logic [DATA_W-1:0] dq_meta_r;
	logic [DATA_W-1:0] dq_sync_r;
	always_ff @(posedge core_clk) begin
		dq_meta_r <= flash_dq_in;
		dq_sync_r <= dq_meta_r;
	end

	// ============================================================
	// sequencer
	state_t state_r;
	logic [7:0] cnt_r;
	logic [DATA_W-1:0] prev_r;
	logic have_prev_r;
	logic recheck_r;
	method_t method_r;
	logic is_erase_r;
	logic [7:0] expect_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] cur;
	logic toggled;
	logic poll_match;
	assign cur = dq_sync_r;
	assign toggled = cur[TOGGLE_BIT] != prev_r[TOGGLE_BIT];
	// erase polling ends at 1; program ends at true bit 7
	assign poll_match = is_erase_r ? cur[POLL_BIT] :
		(cur[POLL_BIT] == expect_r[POLL_BIT]);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cnt_r <= CNT_RESET;
			prev_r <= '0;
			have_prev_r <= 1'b0;
			recheck_r <= 1'b0;
			method_r <= METHOD_TOGGLE;
			is_erase_r <= 1'b0;
			expect_r <= 8'h00;
			addr_r <= '0;
			result <= RES_NONE;
			done <= 1'b0;
			last_status <= '0;
		end else begin
			done <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (start) begin
					// a new start always begins from the first read
					have_prev_r <= 1'b0; // R21
					recheck_r <= 1'b0;
					method_r <= method;
					is_erase_r <= is_erase;
					expect_r <= expect_data;
					// address must be the programmed word or an erase sector
					addr_r <= poll_addr; // R04 R07
					result <= RES_NONE;
					cnt_r <= CNT_RESET;
					state_r <= ST_READ;
				end
			end
			ST_READ: begin
				if (abort) begin
					state_r <= ST_IDLE; // R21
				end else if (cnt_r == 8'(READ_CYCLES + 2)) begin
					// extra two cycles cover the synchroniser
					cnt_r <= CNT_RESET;
					state_r <= ST_EVAL;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
			ST_EVAL: begin
				last_status <= cur;
				prev_r <= cur;
				have_prev_r <= 1'b1;
				state_r <= ST_GAP;
				if (method_r == METHOD_POLL) begin
					if (poll_match) begin
						// bit 7 may lead the rest; finish reads once more
						state_r <= recheck_r ? ST_FINISH : ST_GAP; // R09
						recheck_r <= 1'b1;
						if (recheck_r) begin
							result <= RES_DONE;
						end
					end else if (cur[TIMEOUT_BIT]) begin
						// timeout seen: one more poll read decides
						if (recheck_r) begin
							state_r <= ST_RESET_WR; // R10 R22
						end
						recheck_r <= 1'b1;
					end else begin
						recheck_r <= 1'b0;
					end
				end else if (have_prev_r) begin
					if (!toggled) begin
						result <= RES_DONE; // R18 R19
						state_r <= ST_FINISH;
					end else if (cur[TIMEOUT_BIT]) begin
						if (recheck_r) begin
							state_r <= ST_RESET_WR; // R19
						end
						recheck_r <= 1'b1;
					end
				end
			end
			ST_GAP: begin
				if (abort) begin
					state_r <= ST_IDLE; // R21
				end else if (cnt_r == 8'(STROBE_HIGH_CYCLES)) begin
					cnt_r <= CNT_RESET;
					state_r <= ST_READ;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
			ST_RESET_WR: begin
				if (cnt_r == 8'(READ_CYCLES)) begin
					cnt_r <= CNT_RESET;
					result <= RES_FAIL;
					state_r <= ST_FINISH;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
			ST_FINISH: begin
				// status word only goes to user as status
				done <= 1'b1; // R20
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// pin drive; strobes held high outside reads and the reset command write
	assign busy = (state_r != ST_IDLE);
	assign flash_addr = addr_r;
	assign chip_sel_n = !(state_r == ST_READ || state_r == ST_RESET_WR);
	assign out_strobe_n = !(state_r == ST_READ);
	assign write_strobe_n = !(state_r == ST_RESET_WR &&
		cnt_r < 8'(READ_CYCLES));
	assign flash_dq_out = RESET_CMD;
	assign flash_dq_oe = (state_r == ST_RESET_WR);

	// ============================================================
	// checks
	// a start must open a fresh first read, never reuse old reads
	sequence s_start_taken;
		state_r == ST_IDLE && start;
	endsequence
	sequence s_first_read;
		state_r == ST_READ && !have_prev_r && !recheck_r;
	endsequence
	a_done_pulse_once: assert property ( // R20
		@(posedge core_clk) disable iff (reset)
		done |=> !done) else $error("done longer than one cycle");
	a_fail_sends_reset: assert property ( // R19
		@(posedge core_clk) disable iff (reset)
		(state_r == ST_RESET_WR) |-> flash_dq_oe && !chip_sel_n)
		else $error("reset command not driven");
	a_toggle_done_match: assert property ( // R18
		@(posedge core_clk) disable iff (reset)
		(state_r == ST_EVAL && method_r == METHOD_TOGGLE && have_prev_r
		&& !toggled) |=> result == RES_DONE)
		else $error("unchanged toggle not reported done");
	a_no_write_on_read: assert property ( // R20
		@(posedge core_clk) disable iff (reset)
		!out_strobe_n |-> write_strobe_n && !flash_dq_oe)
		else $error("read and write overlap");
	a_abort_restarts: assert property ( // R21
		@(posedge core_clk) disable iff (reset)
		((state_r == ST_READ || state_r == ST_GAP) && abort)
		|=> state_r == ST_IDLE) else $error("abort ignored");
	a_start_fresh: assert property ( // R21
		@(posedge core_clk) disable iff (reset)
		s_start_taken |=> s_first_read)
		else $error("new check reused earlier reads");
endmodule // flash_op_status_polling

// [verification/flash_status_model.sv]
`timescale 1ns/1ps
// ============================================================
// device side: status bits while an embedded operation runs
module flash_status_model
	import poll_pkg::*;
(
	// flash pins
	input wire logic [ADDR_W-1:0] addr,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] dq
);
	// reads left before the operation ends; a short count stands in
	// for the protected-sector poll window
	int busy_reads = 0;
	int writes = 0;
	logic erase_op = 1'b0;
	logic susp = 1'b0;
	logic settle = 1'b0;
	logic tmo = 1'b0;
	logic in_read = 1'b0;
	logic tog = 1'b0;
	logic tog2 = 1'b0;
	logic [7:0] prog_byte = 8'h00;
	logic [DATA_W-1:0] word;
	always_comb begin
		word = {8'h00, prog_byte};
		if (busy_reads != 0) begin
			// suspended erase reads 1, like a finished one
			word[POLL_BIT] = erase_op ? susp : ~prog_byte[7];
			word[TOGGLE_BIT] = tog;
			word[SECT_TOGGLE_BIT] = erase_op & tog2;
			word[TIMEOUT_BIT] = tmo;
		end else if (settle) begin
			// bit 7 is data already; lower bits lag one read
			word[6:0] = ~prog_byte[6:0];
		end else if (erase_op) begin
			word[7:0] = 8'hFF;
		end
	end
	// released bus shows no stale value
	assign dq = (cs_n | oe_n) ? ~word : word;
	// a read needs both strobes low; either one rising ends it
	always @(cs_n or oe_n) begin
		if (!(cs_n | oe_n)) begin
			in_read = 1'b1;
		end else if (in_read) begin
			in_read = 1'b0;
			settle = 1'b0;
			if (busy_reads != 0) begin
				tog2 = ~tog2;
				// a suspended erase holds its place and stops the global toggle bit
				if (!(susp && erase_op)) begin
					tog = ~tog;
					busy_reads = busy_reads - 1;
					settle = !erase_op && busy_reads == 0;
				end
			end
		end
	end
	// only a selected reset command write counts
	always @(posedge we_n) begin
		if (wdata === RESET_CMD && cs_n === 1'b0) begin
			writes = writes + 1;
			busy_reads = 0;
			settle = 1'b0;
			tmo = 1'b0;
		end
	end
endmodule // flash_status_model

// [verification/flash_op_status_polling_bench.sv]
`timescale 1ns/1ps
module flash_op_status_polling_bench;
	import poll_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, start = 1'b0, abort = 1'b0;
	logic is_erase = 1'b0, busy, done, chip_sel_n, out_strobe_n;
	logic write_strobe_n, flash_dq_oe;
	method_t method = METHOD_TOGGLE;
	result_t result;
	logic [ADDR_W-1:0] poll_addr = 23'h012345, flash_addr;
	logic [7:0] expect_data = 8'h00;
	logic [DATA_W-1:0] last_status, flash_dq_in, flash_dq_out;
	int err_count = 0, samples_checked = 0;
	flash_op_status_polling i_dut (.core_clk(core_clk), .reset(reset),
		.start(start), .abort(abort), .method(method),
		.poll_addr(poll_addr), .expect_data(expect_data),
		.is_erase(is_erase), .busy(busy), .done(done), .result(result),
		.last_status(last_status), .flash_addr(flash_addr),
		.chip_sel_n(chip_sel_n), .out_strobe_n(out_strobe_n),
		.write_strobe_n(write_strobe_n), .flash_dq_in(flash_dq_in),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
	flash_status_model m_flash (.addr(flash_addr), .cs_n(chip_sel_n),
		.oe_n(out_strobe_n), .we_n(write_strobe_n), .wdata(flash_dq_out),
		.dq(flash_dq_in));
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic run(method_t m, logic er, logic [7:0] d, int br,
		logic t, result_t exp_r, logic s = 1'b0);
		int n;
		logic [7:0] st;
		// suspended erase: bit 7 high, sector toggle flipped once
		st = er ? (s ? 8'h84 : 8'hFF) : d;
		m_flash.busy_reads = br;
		m_flash.tmo = t;
		m_flash.erase_op = er;
		m_flash.susp = s;
		m_flash.settle = 1'b0;
		m_flash.tog = 1'b0;
		m_flash.tog2 = 1'b0;
		m_flash.prog_byte = d;
		m_flash.writes = 0;
		method = m;
		is_erase = er;
		expect_data = d;
		start = 1'b1;
		@(posedge core_clk) #1 start = 1'b0;
		check("busy", 16'h0001, 16'(busy));
		for (n = 0; n < 4000 && done !== 1'b1; n++) @(posedge core_clk) #1;
		if (n == 4000) begin
			err_count++;
			summarize();
		end
		check("result", 16'(exp_r), 16'(result));
		check("resets", 16'(exp_r == RES_FAIL), 16'(m_flash.writes));
		check("idle", 16'h0000, 16'(busy));
		check("addr", poll_addr[15:0], flash_addr[15:0]);
		if (exp_r == RES_DONE)
			check("status", {8'h00, st}, last_status & 16'h00FF);
		$display("test end method %0d erase %0d", m, er);
		@(posedge core_clk) #1;
	endtask
	task automatic abort_check();
		m_flash.busy_reads = 900;
		m_flash.tmo = 1'b0;
		m_flash.erase_op = 1'b0;
		m_flash.susp = 1'b0;
		method = METHOD_TOGGLE;
		is_erase = 1'b0;
		start = 1'b1;
		@(posedge core_clk) #1 start = 1'b0;
		// lands inside the second read
		repeat (30) @(posedge core_clk);
		#1 abort = 1'b1;
		@(posedge core_clk) #1 abort = 1'b0;
		check("abort", 16'h0000, 16'(busy));
		$display("test end abort");
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		#1 reset = 1'b0;
		run(METHOD_TOGGLE, 1'b0, 8'h5A, 0, 1'b0, RES_DONE);
		run(METHOD_TOGGLE, 1'b0, 8'h3C, 5, 1'b0, RES_DONE);
		run(METHOD_TOGGLE, 1'b1, 8'h00, 4, 1'b0, RES_DONE);
		run(METHOD_TOGGLE, 1'b0, 8'h11, 900, 1'b1, RES_FAIL);
		run(METHOD_POLL, 1'b0, 8'hA5, 3, 1'b0, RES_DONE);
		run(METHOD_POLL, 1'b0, 8'h2B, 3, 1'b0, RES_DONE);
		run(METHOD_POLL, 1'b1, 8'h00, 3, 1'b0, RES_DONE);
		run(METHOD_POLL, 1'b0, 8'h80, 900, 1'b1, RES_FAIL);
		abort_check();
		run(METHOD_TOGGLE, 1'b1, 8'h00, 50, 1'b0, RES_DONE, 1'b1);
		run(METHOD_POLL, 1'b1, 8'h00, 50, 1'b0, RES_DONE, 1'b1);
		run(METHOD_TOGGLE, 1'b0, 8'h3C, 5, 1'b0, RES_DONE, 1'b1);
		summarize();
	end
endmodule // flash_op_status_polling_bench
